// [design/actc_conversion_timing.sv]
// conversion timing control: APB registers, divider and sample/convert sequencer
//
// Behaviour
// - Writing timing control aborts a running sequence and never starts one.
// - Bit 7 set selects 8-bit results, clear selects 10-bit results.
// - An 8-bit conversion takes fewer conversion clocks than a 10-bit one.
// - Each sample begins with a two conversion clock buffered phase.
// - Bits 6 to 5 pick second phase length 2, 4, 8 or 16 clocks.
// - Second phase connects the input straight to the storage node.
// - Conversion clock is bus clock over 2 times (P+1), divisor 2 to 64.
// - Divider field resets to 5, giving bus clock over 12.
// - Timing control is readable and writable at any time.
// - A register write abort clears the result placement counter.
// - Left justified: 8-bit on bits 8-15, 10-bit on bits 6-15.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module actc_conversion_timing
  import actc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        comparatorIn,
  output logic             bufferToStorage,
  output logic             inputToStorage,
  output logic             converting,
  output logic [15:0]      resultWord,
  output logic             resultValid,
  output logic [2:0]       resultSlot
);
  logic rstMeta_b;
  logic rstSync_b;
  logic cmpMeta;
  logic cmpSync;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      cmpMeta <= 1'b0;
      cmpSync <= 1'b0;
    end else begin
      cmpMeta <= comparatorIn;
      cmpSync <= cmpMeta;
    end
  end

  // apb decode: zero wait states, every access completes in its access cycle
  wire accessPhase = psel && penable;
  wire hitTiming   = (paddr == ACTC_TIMING_OFFSET);
  wire hitControl  = (paddr == ACTC_CONTROL_OFFSET);
  wire hitStatus   = (paddr == ACTC_STATUS_OFFSET);
  wire hitAny      = hitTiming || hitControl || hitStatus;
  wire wrTiming    = accessPhase && pwrite && hitTiming && pstrb[0];
  wire wrControl   = accessPhase && pwrite && hitControl && pstrb[0];
  wire startReq    = wrControl && pwdata[ACTC_CTRL_START];

  actc_timing_s timing;
  logic         scanMode;
  actc_state_e  state;
  actc_state_e  next_state;
  logic [4:0]   phaseCount;
  logic [4:0]   next_phaseCount;
  logic [9:0]   shiftReg;
  logic [2:0]   slot;

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      timing   <= actc_timing_s'(ACTC_TIMING_RESET);
      scanMode <= 1'b0;
    end else begin
      if (wrTiming) begin
        timing <= actc_timing_s'(pwdata[7:0]);
      end
      if (wrControl) begin
        scanMode <= pwdata[ACTC_CTRL_SCAN];
      end
    end
  end

  logic convTick;
  // each sample period starts on a fresh divider phase, so phase one is two whole ticks
  wire  restartDiv = wrTiming || startReq || (state == ACTC_DONE && scanMode);

  actc_clock_divider u_divider (
    .clk_sys   (clk_sys),
    .rstSync_b (rstSync_b),
    .restart   (restartDiv),
    .divider   (timing.conversionClockDivider),
    .convTick  (convTick)
  );

  // second phase length lookup
  wire [1:0] smpCode = timing.secondSamplePhaseLength;
  wire [4:0] phase2Len = (smpCode == 2'b00) ? ACTC_SMP_LEN0 :
                         (smpCode == 2'b01) ? ACTC_SMP_LEN1 :
                         (smpCode == 2'b10) ? ACTC_SMP_LEN2 : ACTC_SMP_LEN3;
  // fewer bits to resolve in low resolution
  wire [4:0] convLen = timing.lowRes ? ACTC_BITS_LOW : ACTC_BITS_HIGH;
  wire       phaseEnd = convTick && (phaseCount == 5'h01);

  // abort takes priority over any start in the same cycle
  always_comb begin
    next_state      = state;
    next_phaseCount = phaseCount;
    if (wrTiming) begin
      next_state      = ACTC_IDLE;
      next_phaseCount = 5'h00;
    end else if (startReq) begin
      next_state      = ACTC_PHASE1;
      next_phaseCount = ACTC_PHASE1_LEN;
    end else begin
      unique case (state)
        ACTC_IDLE: begin
          next_phaseCount = 5'h00;
        end
        ACTC_PHASE1: begin
          if (phaseEnd) begin
            next_state      = ACTC_PHASE2;
            next_phaseCount = phase2Len;
          end else if (convTick) begin
            next_phaseCount = phaseCount - 5'h01;
          end
        end
        ACTC_PHASE2: begin
          if (phaseEnd) begin
            next_state      = ACTC_CONV;
            next_phaseCount = convLen;
          end else if (convTick) begin
            next_phaseCount = phaseCount - 5'h01;
          end
        end
        ACTC_CONV: begin
          if (phaseEnd) begin
            next_state = ACTC_DONE;
          end else if (convTick) begin
            next_phaseCount = phaseCount - 5'h01;
          end
        end
        ACTC_DONE: begin
          next_state      = scanMode ? ACTC_PHASE1 : ACTC_IDLE;
          next_phaseCount = scanMode ? ACTC_PHASE1_LEN : 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      state      <= ACTC_IDLE;
      phaseCount <= 5'h00;
    end else begin
      state      <= next_state;
      phaseCount <= next_phaseCount;
    end
  end

  // successive approximation bits shift in on each conversion clock
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      shiftReg <= 10'h000;
    end else if (state == ACTC_PHASE2 && phaseEnd) begin
      shiftReg <= 10'h000;
    end else if (state == ACTC_CONV && convTick) begin
      shiftReg <= {shiftReg[8:0], cmpSync};
    end
  end

  // left justified placement
  wire [15:0] placedHigh = 16'(shiftReg) << ACTC_HIGH_SHIFT;
  wire [15:0] placedLow  = 16'(shiftReg[7:0]) << ACTC_LOW_SHIFT;
  wire [15:0] placed     = timing.lowRes ? placedLow : placedHigh;
  // an abort in the done cycle drops the result, so word, slot and pulse stay in step
  wire        resultTake = (state == ACTC_DONE) && !wrTiming;

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      resultWord  <= 16'h0000;
      resultValid <= 1'b0;
      slot        <= 3'h0;
    end else begin
      resultValid <= resultTake;
      if (resultTake) begin
        resultWord <= placed;
      end
      if (wrTiming || wrControl) begin
        slot <= 3'h0;
      end else if (resultTake) begin
        slot <= (slot == ACTC_SLOT_LAST) ? 3'h0 : slot + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      resultSlot <= 3'h0;
    end else if (resultTake) begin
      resultSlot <= slot;
    end
  end

  assign bufferToStorage = (state == ACTC_PHASE1);
  assign inputToStorage  = (state == ACTC_PHASE2);
  assign converting      = (state != ACTC_IDLE);

  wire [31:0] statusWord = {24'h000000, 3'h0, slot, 1'b0, converting};
  wire [31:0] readMux = hitTiming  ? {24'h000000, timing} :
                        hitControl ? {30'h00000000, scanMode, 1'b0} :
                        hitStatus  ? statusWord : 32'h00000000;

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= readMux;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = accessPhase && !hitAny;
endmodule : actc_conversion_timing
`default_nettype wire

// [design/actc_pkg.sv]
// shared constants and types for the conversion timing control block
package actc_pkg;
  // register map
  localparam logic [11:0] ACTC_TIMING_OFFSET  = 12'h000;
  localparam logic [11:0] ACTC_CONTROL_OFFSET = 12'h004;
  localparam logic [11:0] ACTC_STATUS_OFFSET  = 12'h008;

  localparam logic [7:0] ACTC_TIMING_RESET = 8'h05;

  // timing control field positions
  localparam int ACTC_RES_BIT    = 7;
  localparam int ACTC_SMP_HI     = 6;
  localparam int ACTC_SMP_LO     = 5;
  localparam int ACTC_PRS_HI     = 4;
  localparam int ACTC_PRS_LO     = 0;

  // control register bits
  localparam int ACTC_CTRL_START = 0;
  localparam int ACTC_CTRL_SCAN  = 1;

  // phase lengths in conversion clock cycles
  localparam logic [4:0] ACTC_PHASE1_LEN = 5'h02;
  localparam logic [4:0] ACTC_SMP_LEN0   = 5'h02;
  localparam logic [4:0] ACTC_SMP_LEN1   = 5'h04;
  localparam logic [4:0] ACTC_SMP_LEN2   = 5'h08;
  localparam logic [4:0] ACTC_SMP_LEN3   = 5'h10;
  localparam logic [4:0] ACTC_BITS_HIGH  = 5'h0a;
  localparam logic [4:0] ACTC_BITS_LOW   = 5'h08;

  // result placement
  localparam int ACTC_RESULT_W = 10;
  localparam int ACTC_HIGH_SHIFT = 6;
  localparam int ACTC_LOW_SHIFT  = 8;
  localparam logic [2:0] ACTC_SLOT_LAST = 3'h7;

  typedef struct packed {
    logic       lowRes;
    logic [1:0] secondSamplePhaseLength;
    logic [4:0] conversionClockDivider;
  } actc_timing_s;

  typedef enum logic [4:0] {
    ACTC_IDLE   = 5'b00001,
    ACTC_PHASE1 = 5'b00010,
    ACTC_PHASE2 = 5'b00100,
    ACTC_CONV   = 5'b01000,
    ACTC_DONE   = 5'b10000
  } actc_state_e;
endpackage : actc_pkg

// [design/actc_clock_divider.sv]
// conversion clock divider: one tick every 2*(P+1) bus clocks
`timescale 1ns/1ps
`default_nettype none
module actc_clock_divider
  import actc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rstSync_b,
  input  wire logic       restart,
  input  wire logic [4:0] divider,
  output logic            convTick
);
  logic [5:0] count;
  wire  [5:0] terminal = {divider, 1'b1};
  wire        atEnd    = (count == terminal);

  // restart gives the new divisor a clean phase
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      count    <= 6'h00;
      convTick <= 1'b0;
    end else if (restart) begin
      // the tick is registered, so a restart starts one count in to keep whole periods
      count    <= 6'h01;
      convTick <= 1'b0;
    end else begin
      count    <= atEnd ? 6'h00 : count + 6'h01;
      convTick <= atEnd;
    end
  end
endmodule : actc_clock_divider
`default_nettype wire

// [bench/actc_conversion_timing_properties.sv]
// port checks for the conversion timing control block
`timescale 1ns/1ps
`default_nettype none
module actc_conversion_timing_properties
  import actc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        comparatorIn,
  input wire logic        bufferToStorage,
  input wire logic        inputToStorage,
  input wire logic        converting,
  input wire logic [15:0] resultWord,
  input wire logic        resultValid,
  input wire logic [2:0]  resultSlot
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic acc  = psel && penable;
  wire logic wrOk = acc && pwrite && pstrb[0];
  wire logic tWr  = wrOk && paddr == ACTC_TIMING_OFFSET;
  wire logic sWr  = wrOk && paddr == ACTC_CONTROL_OFFSET && pwdata[0];
  wire logic bad  = paddr > ACTC_STATUS_OFFSET || paddr[1:0] != 2'h0;
  chk_abort_idle: assert property (
    tWr |=> !converting && !bufferToStorage) else $error("abort left sequencer busy");
  chk_start_phase: assert property (
    sWr |=> bufferToStorage && converting) else $error("start gave no first phase");
  chk_phase_excl: assert property (
    !(bufferToStorage && inputToStorage)) else $error("both sample phases on");
  chk_phase_order: assert property (
    $rose(inputToStorage) |-> $past(bufferToStorage)) else $error("second phase too early");
  chk_valid_pulse: assert property (
    resultValid |=> !resultValid) else $error("result pulse too long");
  chk_bad_refused: assert property (
    acc && bad |-> pslverr && (pwrite || prdata == 32'h0)) else $error("bad address taken");
  chk_good_ok: assert property (
    acc && !bad |-> !pslverr) else $error("mapped access refused");
  chk_upper_zero: assert property (
    acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  cover property (tWr && converting);
  cover property ($rose(inputToStorage));
  cover property (resultValid);
endmodule // actc_conversion_timing_properties
bind actc_conversion_timing actc_conversion_timing_properties u_props (
  .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .comparatorIn, .bufferToStorage, .inputToStorage,
  .converting, .resultWord, .resultValid, .resultSlot
);
`default_nettype wire

// [bench/test_actc_conversion_timing.sv]
// directed bench for the conversion timing control block
`timescale 1ns/1ps
`default_nettype none
module test_actc_conversion_timing;
  import actc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        comparatorIn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata, rdData;
  logic [15:0] resultWord;
  logic [2:0]  resultSlot;
  logic [4:0]  p;
  logic [1:0]  s;
  logic        r, lastErr, pready, pslverr, resultValid;
  logic        bufferToStorage, inputToStorage, converting;
  int          errors = 0, cmp_count = 0, cyc = 0, n1, n2, n3, n3a;
  always #12.5 clk_sys = ~clk_sys;
  actc_conversion_timing u_actc_conversion_timing (
    .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .comparatorIn, .bufferToStorage, .inputToStorage,
    .converting, .resultWord, .resultValid, .resultSlot
  );
  task close_out;
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // whole run needs well under 8000 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      close_out;
    end
  end
  task cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdData = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // n1/n2: first/second phase cycles, n3: cycles from its end to the result pulse
  task meas;
    n1 = 0;
    n2 = 0;
    n3 = 0;
    while (inputToStorage !== 1'b1) begin
      n1 += (bufferToStorage === 1'b1);
      @(negedge clk_sys);
    end
    while (inputToStorage === 1'b1) begin
      n2++;
      @(negedge clk_sys);
    end
    while (resultValid !== 1'b1) begin
      n3++;
      @(negedge clk_sys);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    xfer(1'b0, ACTC_TIMING_OFFSET, 32'h0);
    cmp(rdData, 32'h5);
    xfer(1'b1, ACTC_TIMING_OFFSET, 32'hffffffff);
    pstrb <= 4'he;
    xfer(1'b1, ACTC_TIMING_OFFSET, 32'h0);
    pstrb <= 4'hf;
    xfer(1'b1, 12'h00c, 32'h0);
    cmp({31'h0, lastErr}, 32'h1);
    xfer(1'b0, ACTC_TIMING_OFFSET, 32'h0);
    cmp(rdData, 32'hff);
    xfer(1'b0, 12'h00c, 32'h0);
    cmp(rdData, 32'h0);
    // divider 9 to 31 keeps the conversion clock in range at 40 MHz
    for (int i = 0; i < 5; i++) begin
      p = (i >= 3) ? 5'h1f : 5'(9 + i);
      s = 2'(i % 4);
      r = (i == 4);
      comparatorIn <= (i % 2 == 1) || r;
      xfer(1'b1, ACTC_TIMING_OFFSET, {24'h0, r, s, p});
      xfer(1'b1, ACTC_CONTROL_OFFSET, 32'h1);
      meas;
      cmp(n1, 4 * (p + 1));
      cmp(n2, (2 << s) * 2 * (p + 1));
      cmp(resultWord, (i % 2 == 0 && !r) ? 16'h0 : (r ? 16'hff00 : 16'hffc0));
      if (i == 3)
        n3a = n3;
    end
    cmp(n3a - n3, 32'd128);
    xfer(1'b1, ACTC_TIMING_OFFSET, 32'h9);
    xfer(1'b1, ACTC_CONTROL_OFFSET, 32'h3);
    meas;
    meas;
    cmp(n1, 32'd40);
    cmp({29'h0, resultSlot}, 32'h1);
    xfer(1'b0, ACTC_STATUS_OFFSET, 32'h0);
    cmp(rdData, 32'h9);
    xfer(1'b1, ACTC_TIMING_OFFSET, 32'h9);
    xfer(1'b0, ACTC_STATUS_OFFSET, 32'h0);
    cmp(rdData, 32'h0);
    n3 = 0;
    repeat (200) begin
      @(negedge clk_sys);
      n3 += (resultValid === 1'b1);
    end
    cmp(n3, 32'h0);
    close_out;
  end
endmodule // test_actc_conversion_timing
`default_nettype wire
